// [nvw_cfg.svh]
// offsets, field positions, reset values and timing for the nv write control block
`ifndef NVW_CFG_SVH
`define NVW_CFG_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define NVW_OFF_ADDR_HI 8'h00
`define NVW_OFF_ADDR_LO 8'h04
`define NVW_OFF_DATA 8'h08
`define NVW_OFF_CTRL 8'h0C
`define NVW_OFF_KEY 8'h10
`define NVW_OFF_STAT 8'h14
`define NVW_OFF_PROT 8'h18
// ------------------------------------------------------------
// nv_control fields
// ------------------------------------------------------------
`define NVW_CTL_PGM_SEL 7
`define NVW_CTL_CFG_SEL 6
`define NVW_CTL_WRITE_EN 2
`define NVW_CTL_WR 1
// ------------------------------------------------------------
// status and protect fields
// ------------------------------------------------------------
`define NVW_ST_DONE 0
`define NVW_ST_PWRT 1
`define NVW_ST_BUSY 2
`define NVW_PR_EN 0
// ------------------------------------------------------------
// key values, reset values, responses
// ------------------------------------------------------------
`define NVW_KEY_1 8'h55
`define NVW_KEY_2 8'hAA
`define NVW_RST_BYTE 8'h00
`define NVW_RESP_OK 2'h0
`define NVW_RESP_ERR 2'h2
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define NVW_CLK_NS 8
`define NVW_PWRT_MS 72
`define NVW_PWRT_CYC (`NVW_PWRT_MS * 1000000 / `NVW_CLK_NS)
`define NVW_WRCYC_CYC 1000
`endif

// [nvw_pkg.sv]
// types shared by the nv write control modules
`default_nettype none
package nvw_pkg;
  typedef enum logic [1:0] {UNL_IDLE, UNL_GOT_FIRST, UNL_ARMED} nvw_unl_t;
endpackage : nvw_pkg
`default_nettype wire

// [nvw_seq_if.sv]
// unlock tracker link between the register file and the sequence tracker
`timescale 1ns/1ns
`default_nettype none
interface nvw_seq_if;
  logic acc;
  logic key_wr;
  logic [7:0] key_val;
  logic armed;
  modport trk (input acc, input key_wr, input key_val, output armed);
  modport regs (output acc, output key_wr, output key_val, input armed);
endinterface : nvw_seq_if
`default_nettype wire

// [nvw_unlock.sv]
// unlock sequence tracker: key one, key two, then arm for one access
`timescale 1ns/1ns
`default_nettype none
`include "nvw_cfg.svh"
module nvw_unlock (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register file side
  nvw_seq_if.trk seq
);
  nvw_pkg::nvw_unl_t st_q;

  // ------------------------------------------------------------
  // sequence state
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= nvw_pkg::UNL_IDLE;
    end else if (seq.acc) begin
      case (st_q)
        nvw_pkg::UNL_IDLE: begin
          if (seq.key_wr && seq.key_val == `NVW_KEY_1) st_q <= nvw_pkg::UNL_GOT_FIRST; // RULE_02
        end
        nvw_pkg::UNL_GOT_FIRST: begin
          if (seq.key_wr && seq.key_val == `NVW_KEY_2) st_q <= nvw_pkg::UNL_ARMED; // RULE_02
          else st_q <= nvw_pkg::UNL_IDLE; // RULE_20
        end
        // the access seen while armed is the start attempt or a deviation
        default: st_q <= nvw_pkg::UNL_IDLE; // RULE_20
      endcase
    end
  end

  assign seq.armed = (st_q == nvw_pkg::UNL_ARMED);
endmodule : nvw_unlock
`default_nettype wire

// [nvw_timer.sv]
// down counter timing one interval, optionally running from reset
`timescale 1ns/1ns
`default_nettype none
module nvw_timer #(
  parameter int unsigned CYCLES = 1000,
  parameter bit RUN_AT_RESET = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);
  localparam logic [W-1:0] RST_CNT = RUN_AT_RESET ? LOAD : '0;
  logic [W-1:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= RST_CNT;
    end else if (start && cnt_q == '0) begin
      cnt_q <= LOAD;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign busy = (cnt_q != '0);
  assign done = (cnt_q == W'(1));
endmodule : nvw_timer
`default_nettype wire

// [nvw_top.sv]
// data eeprom write control with axi4-lite register access
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "nvw_cfg.svh"
// Contract
// RULE_01: software loads both address registers and the data byte before starting.
// RULE_02: write starts only after key 55h, key AAh, then write-start, per byte.
// RULE_03: software should disable interrupts around the unlock-and-start sequence.
// RULE_04: write-start is refused unless write-enable was already set.
// RULE_05: one write setting write-enable and write-start together starts nothing.
// RULE_06: hardware never changes write-enable when a cycle completes.
// RULE_07: software keeps write-enable clear except while updating, clears after completion.
// RULE_08: while a cycle runs, control, address and data registers ignore writes.
// RULE_09: at cycle end hardware clears write-start and sets the done flag.
// RULE_10: only software clears the done flag; it may be polled.
// RULE_11: reset clears write-enable.
// RULE_12: no write may start while the power-up timer runs, nominally 72 ms.
// RULE_13: protection enabled disables external programming access to the array.
// RULE_14: the processor can always read and write, whatever the protection setting.
// RULE_15: software may read back each written location to verify it.
// RULE_16: software refreshes the whole array if values are rarely rewritten.
// RULE_17: software clears both memory-select bits before unlocking.
// RULE_18: program-memory select is control bit 7, config-space select bit 6.
// RULE_19: software only sets write-start; writing zero has no effect.
// RULE_20: any access other than the next expected step returns the tracker to idle.
// RULE_21: write cycle length is a parameter; start bit and lock hold throughout.
module nvw_top #(
  parameter int unsigned ADDR_HI_W = 2,
  parameter int unsigned PWRT_CYCLES = `NVW_PWRT_CYC,
  parameter int unsigned WRCYC_CYCLES = `NVW_WRCYC_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // array write port
  output logic nv_mem_wr_q,
  output logic [ADDR_HI_W+7:0] nv_mem_addr_q,
  output logic [7:0] nv_mem_data_q,
  // external programming interface gate
  output logic ext_access_en_q
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic aw_rdy_q;
  logic w_rdy_q;
  logic b_vld_q;
  logic [1:0] b_resp_q;
  logic ar_rdy_q;
  logic r_vld_q;
  logic [1:0] r_resp_q;
  logic [31:0] r_data_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_lane0_q;
  logic [ADDR_HI_W-1:0] addr_hi_q;
  logic [7:0] addr_lo_q;
  logic [7:0] data_q;
  logic pgm_sel_q;
  logic cfg_sel_q;
  logic write_enable_q;
  logic wr_q;
  logic done_q;
  logic prot_q;

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  logic wr_fire;
  logic rd_fire;
  logic wr_lane;
  logic wr_hit;
  logic wr_ctl;
  logic start_ok;
  logic start_go;
  logic cyc_busy;
  logic cyc_done;
  logic pwrt_busy;
  logic wr_mapped;
  logic rd_mapped;
  logic [31:0] rd_val;

  nvw_seq_if seq ();

  assign wr_fire = !aw_rdy_q && !w_rdy_q && !b_vld_q;
  assign rd_fire = s_axi_arvalid && ar_rdy_q;
  assign wr_lane = wr_fire && w_lane0_q;
  assign wr_ctl = wr_lane && aw_addr_q == `NVW_OFF_CTRL;
  assign wr_hit = wr_lane && !cyc_busy && !wr_q;

  // start needs armed tracker, previously set enable, idle cycle, expired power-up timer
  assign start_ok = seq.armed && write_enable_q && !wr_q && !pwrt_busy; // RULE_04 RULE_05 RULE_12
  assign start_go = wr_ctl && w_data_q[`NVW_CTL_WR] && start_ok; // RULE_02

  // both bus reads and writes count as accesses for the tracker
  assign seq.acc = wr_fire || rd_fire; // RULE_20
  assign seq.key_wr = wr_lane && aw_addr_q == `NVW_OFF_KEY;
  assign seq.key_val = w_data_q[7:0];

  always_comb begin
    case (aw_addr_q)
      `NVW_OFF_ADDR_HI, `NVW_OFF_ADDR_LO, `NVW_OFF_DATA, `NVW_OFF_CTRL,
      `NVW_OFF_KEY, `NVW_OFF_STAT, `NVW_OFF_PROT: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      `NVW_OFF_ADDR_HI: rd_val[ADDR_HI_W-1:0] = addr_hi_q;
      `NVW_OFF_ADDR_LO: rd_val[7:0] = addr_lo_q;
      `NVW_OFF_DATA: rd_val[7:0] = data_q;
      `NVW_OFF_CTRL: begin
        rd_val[`NVW_CTL_PGM_SEL] = pgm_sel_q;
        rd_val[`NVW_CTL_CFG_SEL] = cfg_sel_q;
        rd_val[`NVW_CTL_WRITE_EN] = write_enable_q;
        rd_val[`NVW_CTL_WR] = wr_q;
      end
      // key register is not physical and reads as zero
      `NVW_OFF_KEY: rd_val = 32'h0000_0000;
      `NVW_OFF_STAT: begin
        rd_val[`NVW_ST_DONE] = done_q; // RULE_10
        rd_val[`NVW_ST_PWRT] = pwrt_busy;
        rd_val[`NVW_ST_BUSY] = cyc_busy;
      end
      `NVW_OFF_PROT: rd_val[`NVW_PR_EN] = prot_q;
      default: rd_mapped = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // axi write channels
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_q <= 1'b1;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && aw_rdy_q) begin
      aw_rdy_q <= 1'b0;
      aw_addr_q <= s_axi_awaddr;
    end else if (b_vld_q && s_axi_bready) begin
      aw_rdy_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_rdy_q <= 1'b1;
      w_data_q <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
    end else if (s_axi_wvalid && w_rdy_q) begin
      w_rdy_q <= 1'b0;
      w_data_q <= s_axi_wdata;
      w_lane0_q <= s_axi_wstrb[0];
    end else if (b_vld_q && s_axi_bready) begin
      w_rdy_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_vld_q <= 1'b0;
      b_resp_q <= `NVW_RESP_OK;
    end else if (wr_fire) begin
      b_vld_q <= 1'b1;
      b_resp_q <= wr_mapped ? `NVW_RESP_OK : `NVW_RESP_ERR;
    end else if (b_vld_q && s_axi_bready) begin
      b_vld_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // axi read channels
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_q <= 1'b1;
      r_vld_q <= 1'b0;
      r_resp_q <= `NVW_RESP_OK;
      r_data_q <= 32'h0000_0000;
    end else if (rd_fire) begin
      ar_rdy_q <= 1'b0;
      r_vld_q <= 1'b1;
      r_resp_q <= rd_mapped ? `NVW_RESP_OK : `NVW_RESP_ERR;
      r_data_q <= rd_val;
    end else if (r_vld_q && s_axi_rready) begin
      ar_rdy_q <= 1'b1;
      r_vld_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // address and data registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_hi_q <= '0;
      addr_lo_q <= `NVW_RST_BYTE;
      data_q <= `NVW_RST_BYTE;
    end else if (wr_hit) begin // RULE_08
      if (aw_addr_q == `NVW_OFF_ADDR_HI) addr_hi_q <= w_data_q[ADDR_HI_W-1:0];
      if (aw_addr_q == `NVW_OFF_ADDR_LO) addr_lo_q <= w_data_q[7:0];
      if (aw_addr_q == `NVW_OFF_DATA) data_q <= w_data_q[7:0];
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pgm_sel_q <= 1'b0;
      cfg_sel_q <= 1'b0;
      write_enable_q <= 1'b0; // RULE_11
    end else if (wr_hit && wr_ctl) begin // RULE_08
      pgm_sel_q <= w_data_q[`NVW_CTL_PGM_SEL]; // RULE_18
      cfg_sel_q <= w_data_q[`NVW_CTL_CFG_SEL]; // RULE_18
      write_enable_q <= w_data_q[`NVW_CTL_WRITE_EN];
    end
  end

  // write-start: set only by an armed start, cleared only by cycle end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= 1'b0;
    end else if (start_go) begin
      wr_q <= 1'b1; // RULE_02 RULE_19
    end else if (cyc_done) begin
      wr_q <= 1'b0; // RULE_09 RULE_06
    end
  end

  // done flag: set beats a same-cycle software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (cyc_done) begin
      done_q <= 1'b1; // RULE_09
    end else if (wr_lane && aw_addr_q == `NVW_OFF_STAT && w_data_q[`NVW_ST_DONE]) begin
      done_q <= 1'b0; // RULE_10
    end
  end

  // ------------------------------------------------------------
  // protection and array port
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prot_q <= 1'b0;
      ext_access_en_q <= 1'b1;
    end else begin
      if (wr_lane && aw_addr_q == `NVW_OFF_PROT) prot_q <= w_data_q[`NVW_PR_EN];
      // only the external path is gated; the processor path is never checked
      ext_access_en_q <= !prot_q; // RULE_13 RULE_14
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_mem_wr_q <= 1'b0;
      nv_mem_addr_q <= '0;
      nv_mem_data_q <= `NVW_RST_BYTE;
    end else begin
      // strobe only toward the data array; other memory spaces are not served here
      nv_mem_wr_q <= start_go && !pgm_sel_q && !cfg_sel_q; // RULE_14
      nv_mem_addr_q <= {addr_hi_q, addr_lo_q};
      nv_mem_data_q <= data_q;
    end
  end

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  nvw_unlock u_unlock (
    .aclk(aclk),
    .aresetn(aresetn),
    .seq(seq.trk)
  );

  nvw_timer #(
    .CYCLES(WRCYC_CYCLES),
    .RUN_AT_RESET(1'b0)
  ) u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_go), // RULE_21
    .busy(cyc_busy),
    .done(cyc_done)
  );

  nvw_timer #(
    .CYCLES(PWRT_CYCLES),
    .RUN_AT_RESET(1'b1)
  ) u_pwrt (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(1'b0),
    .busy(pwrt_busy), // RULE_12
    .done()
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = w_rdy_q;
  assign s_axi_bvalid = b_vld_q;
  assign s_axi_bresp = b_resp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid = r_vld_q;
  assign s_axi_rresp = r_resp_q;
  assign s_axi_rdata = r_data_q;
endmodule : nvw_top
`default_nettype wire

// [nvw_asserts.sv]
// port assertions for the nv write control block
`timescale 1ns/1ns
`default_nettype none
module nvw_asserts #(
  parameter int unsigned ADDR_HI_W = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // array and external gate
  input wire logic nv_mem_wr_q,
  input wire logic [ADDR_HI_W+7:0] nv_mem_addr_q,
  input wire logic [7:0] nv_mem_data_q,
  input wire logic ext_access_en_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // bus handshakes
  // ------------------------------------------------------------
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_ready_return: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write channels not ready again");
  // ------------------------------------------------------------
  // write cycle
  // ------------------------------------------------------------
  a_strobe_pulse: assert property (nv_mem_wr_q |=> (!nv_mem_wr_q)[*8])
    else $error("array strobe repeated inside a cycle");
  a_strobe_cause: assert property (nv_mem_wr_q |-> $rose(s_axi_bvalid))
    else $error("array strobe without a register write");
  a_lock_hold: assert property (nv_mem_wr_q |=> ($stable(nv_mem_addr_q) && $stable(nv_mem_data_q))[*8])
    else $error("address or data changed during a cycle");
  a_gate_cause: assert property ($changed(ext_access_en_q) |-> $past(s_axi_bvalid))
    else $error("external gate changed without a write");
  c_strobe: cover property (nv_mem_wr_q);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_gate_off: cover property (!ext_access_en_q);
endmodule : nvw_asserts
bind nvw_top nvw_asserts #(.ADDR_HI_W(ADDR_HI_W)) u_nvw_asserts (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .nv_mem_wr_q, .nv_mem_addr_q, .nv_mem_data_q, .ext_access_en_q);
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the nv write control block
`timescale 1ns/1ns
`default_nettype none
`include "nvw_cfg.svh"
module tb_top;
  localparam logic [7:0] AH = `NVW_OFF_ADDR_HI;
  localparam logic [7:0] AL = `NVW_OFF_ADDR_LO;
  localparam logic [7:0] DT = `NVW_OFF_DATA;
  localparam logic [7:0] CT = `NVW_OFF_CTRL;
  localparam logic [7:0] KY = `NVW_OFF_KEY;
  localparam logic [7:0] ST = `NVW_OFF_STAT;
  localparam logic [7:0] PR = `NVW_OFF_PROT;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nv_mem_wr_q, ext_access_en_q;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [9:0] nv_mem_addr_q, last_a;
  logic [7:0] nv_mem_data_q, last_d;
  int mismatches = 0, n_compared = 0, cyc = 0, strobes = 0;
  always #4 aclk = ~aclk;
  nvw_top #(.PWRT_CYCLES(20), .WRCYC_CYCLES(20)) u_nvw_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .nv_mem_wr_q, .nv_mem_addr_q, .nv_mem_data_q, .ext_access_en_q);
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, (a > PR) ? `NVW_RESP_ERR : `NVW_RESP_OK});
    @(posedge aclk);
  endtask : rd
  task automatic start(input logic [31:0] c);
    wr(KY, 32'h55, 2'h0);
    wr(KY, 32'hAA, 2'h0);
    wr(CT, c, 2'h0);
  endtask : start
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  always @(posedge aclk) begin
    cyc++;
    if (nv_mem_wr_q === 1'b1) begin
      strobes++;
      last_a = nv_mem_addr_q;
      last_d = nv_mem_data_q;
    end
    if (cyc == 3000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(CT, 32'h04, 2'h0);
    rd(ST, 32'h02);
    start(32'h06);
    rd(CT, 32'h04);
    repeat (30) @(posedge aclk);
    rd(ST, 32'h00);
    wr(AH, 32'h03, 2'h0);
    wr(AL, 32'hA5, 2'h0);
    wr(DT, 32'h3C, 2'h0);
    start(32'h06);
    wr(CT, 32'h00, 2'h0);
    wr(DT, 32'h77, 2'h0);
    rd(CT, 32'h06);
    rd(ST, 32'h04);
    rd(DT, 32'h3C);
    repeat (12) @(posedge aclk);
    rd(CT, 32'h04);
    rd(ST, 32'h01);
    chk(strobes, 32'h0000_0001);
    chk({22'h0, last_a}, 32'h0000_03A5);
    chk({24'h0, last_d}, 32'h0000_003C);
    rd(ST, 32'h01);
    wr(ST, 32'h01, 2'h0);
    rd(ST, 32'h00);
    wr(CT, 32'h00, 2'h0);
    start(32'h06);
    rd(CT, 32'h04);
    wr(KY, 32'hAA, 2'h0);
    wr(KY, 32'h55, 2'h0);
    wr(CT, 32'h06, 2'h0);
    wr(KY, 32'h55, 2'h0);
    rd(CT, 32'h04);
    wr(KY, 32'hAA, 2'h0);
    wr(CT, 32'h06, 2'h0);
    rd(CT, 32'h04);
    chk(strobes, 32'h0000_0001);
    wr(8'h1C, 32'h01, 2'h2);
    rd(8'h1C, 32'h00);
    // a write with lane zero disabled leaves the data byte alone
    s_axi_wstrb <= 4'h0;
    wr(DT, 32'h99, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(DT, 32'h3C);
    wr(PR, 32'h01, 2'h0);
    chk({31'h0, ext_access_en_q}, 32'h0);
    start(32'h06);
    repeat (12) @(posedge aclk);
    chk(strobes, 32'h0000_0002);
    chk({22'h0, last_a}, 32'h0000_03A5);
    chk({24'h0, last_d}, 32'h0000_003C);
    wr(PR, 32'h00, 2'h0);
    chk({31'h0, ext_access_en_q}, 32'h1);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CT, 32'h00);
    rd(ST, 32'h02);
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
